// ==== core/dbs_controller_end.sv ====
`timescale 1ns/1ps
module dbs_controller_end #(
    parameter int BW = dbs_pkg::BEAT_WIDTH,
    parameter int AW = dbs_pkg::ADDR_WIDTH
) (
    dbs_if.controller link,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqRead,
    input wire logic [AW-1:0] reqAddr,
    input wire logic [2*BW-1:0] reqData,
    input wire logic [2*BW/dbs_pkg::BYTE_BITS-1:0] reqMaskN,
    output logic rspValid,
    input wire logic rspReady,
    output logic [2*BW-1:0] rspData
);
    localparam int MW = BW / dbs_pkg::BYTE_BITS;
    logic phase;
    logic [2*BW-1:0] wrData;
    logic [2*MW-1:0] wrMask;
    logic wrBeat1;
    logic wrBeat2;
    logic [BW-1:0] rdLow;
    logic [1:0] bufCount;
    logic [2*BW-1:0] buffer [2];
    logic bufHead;
    logic pushWord;
    logic [2*BW-1:0] pushData;
    logic [2*BW-1:0] beatData;
    logic [2*MW-1:0] beatMask;
    logic [1:0] readsInFlight;
    logic [1:0] turnWait;
    logic takeReq;

    // phase 0 = true-clock edge, 1 = complement edge
    assign link.kRise = !phase;
    assign link.kbRise = phase;
    assign takeReq = reqValid && reqReady;
    // reads in flight hold a buffer slot, so a stalled receiver loses no word
    // a write waits two slots after a read so the bus turns round cleanly
    assign reqReady = !phase && (reqRead ?
        ({1'b0, bufCount} + {1'b0, readsInFlight}) < 3'h2 : turnWait == 2'h0);

    always_ff @(posedge link.clock) begin
        if (link.reset) begin
            phase <= 1'b0;
            link.load_n <= 1'b1;
            link.readNotWrite <= 1'b1;
            link.sync_address_in <= '0;
            wrBeat1 <= 1'b0;
            wrBeat2 <= 1'b0;
            wrData <= '0;
            wrMask <= '1;
            beatData <= '0;
            beatMask <= '1;
            turnWait <= 2'h0;
        end else begin
            phase <= !phase;
            if (!phase) begin
                link.load_n <= !takeReq;
                link.readNotWrite <= reqRead;
                link.sync_address_in <= reqAddr;
                wrBeat1 <= takeReq && !reqRead;
                if (takeReq && !reqRead) begin
                    wrData <= reqData;
                    wrMask <= reqMaskN;
                end
                // second stage frees the first for a back-to-back write
                wrBeat2 <= wrBeat1;
                beatData <= wrData;
                beatMask <= wrMask;
                if (takeReq && reqRead) begin
                    turnWait <= 2'h2;
                end else if (turnWait != 2'h0) begin
                    turnWait <= turnWait - 2'h1;
                end
            end
        end
    end

    // late write: beat one one cycle after the command, masks per beat
    always_ff @(posedge link.clock) begin
        if (link.reset) begin
            link.ctlDataOut <= '0;
            link.ctlDataOe <= 1'b0;
            link.byte_write_mask_n <= '1;
        end else if (phase && wrBeat2) begin
            link.ctlDataOut <= beatData[BW-1:0];
            link.byte_write_mask_n <= beatMask[MW-1:0];
            link.ctlDataOe <= 1'b1;
        end else if (!phase && wrBeat2) begin
            link.ctlDataOut <= beatData[2*BW-1:BW];
            link.byte_write_mask_n <= beatMask[2*MW-1:MW];
        end else if (phase) begin
            link.ctlDataOe <= 1'b0;
            link.byte_write_mask_n <= '1;
        end
    end

    assign link.pll_disable_n = 1'b1;
    assign link.termination_enable = 1'b1;
    assign link.impedance_reference = 1'b0;

    // ****************************************
    // read return buffer
    // ****************************************
    assign pushWord = link.read_valid_out && link.echoClockN;
    assign pushData = {link.dataBus, rdLow};
    assign rspValid = bufCount != 2'h0;
    assign rspData = buffer[bufHead];

    always_ff @(posedge link.clock) begin
        if (link.reset) begin
            rdLow <= '0;
            bufCount <= 2'h0;
            bufHead <= 1'b0;
            buffer[0] <= '0;
            buffer[1] <= '0;
            readsInFlight <= 2'h0;
        end else begin
            readsInFlight <= readsInFlight + {1'b0, takeReq && reqRead} - {1'b0, pushWord};
            if (link.read_valid_out && link.echo_clock) begin
                rdLow <= link.dataBus;
            end
            if (pushWord) begin
                buffer[bufHead ^ bufCount[0]] <= pushData;
            end
            if (rspValid && rspReady) begin
                bufHead <= !bufHead;
            end
            bufCount <= bufCount + {1'b0, pushWord} - {1'b0, rspValid && rspReady};
        end
    end
endmodule // dbs_controller_end

// ==== core/dbs_if.sv ====
`timescale 1ns/1ps
interface dbs_if #(
    parameter int BW = dbs_pkg::BEAT_WIDTH,
    parameter int AW = dbs_pkg::ADDR_WIDTH
) (
    input wire logic clock,
    input wire logic reset
);
    logic kRise;
    logic kbRise;
    logic [AW-1:0] sync_address_in;
    logic load_n;
    logic readNotWrite;
    logic [BW/dbs_pkg::BYTE_BITS-1:0] byte_write_mask_n;
    logic [BW-1:0] ctlDataOut;
    logic ctlDataOe;
    logic [BW-1:0] memDataOut;
    logic memDataOe;
    logic echo_clock;
    logic echoClockN;
    logic read_valid_out;
    logic pll_disable_n;
    logic termination_enable;
    logic impedance_reference;
    // resolved common data bus; an undriven bus shows garbage so a mistimed beat is caught
    wire logic [BW-1:0] dataBus = memDataOe ? memDataOut : (ctlDataOe ? ctlDataOut : ~ctlDataOut);

    modport memory (
        input clock, reset, kRise, kbRise, sync_address_in, load_n, readNotWrite,
        input byte_write_mask_n, dataBus, pll_disable_n, termination_enable,
        input impedance_reference,
        output memDataOut, memDataOe, echo_clock, echoClockN, read_valid_out
    );
    modport controller (
        input clock, reset, dataBus, echo_clock, echoClockN, read_valid_out,
        output kRise, kbRise, sync_address_in, load_n, readNotWrite,
        output byte_write_mask_n, ctlDataOut, ctlDataOe, pll_disable_n,
        output termination_enable, impedance_reference
    );
endinterface

// ==== core/dbs_impedance_cal.sv ====
`timescale 1ns/1ps
module dbs_impedance_cal #(
    parameter int INTERVAL = dbs_pkg::CAL_INTERVAL_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic tiedToSupply,
    input wire logic [dbs_pkg::IMP_CODE_WIDTH-1:0] targetCode,
    output logic [dbs_pkg::IMP_CODE_WIDTH-1:0] driverCode,
    output logic evalPulse
);
    logic [15:0] cycleCount;

    always_ff @(posedge clock) begin
        if (reset || evalPulse) begin
            cycleCount <= 16'h0000;
        end else begin
            cycleCount <= cycleCount + 16'h0001;
        end
    end
    assign evalPulse = (cycleCount == 16'(INTERVAL - 1));

    always_ff @(posedge clock) begin
        if (reset) begin
            driverCode <= dbs_pkg::IMP_CODE_RESET;
        end else if (tiedToSupply) begin
            driverCode <= dbs_pkg::IMP_CODE_MIN;
        end else if (evalPulse) begin
            // one step only, so drift is tracked without glitching the driver
            if (targetCode > driverCode) begin
                driverCode <= driverCode + 4'h1;
            end else if (targetCode < driverCode) begin
                driverCode <= driverCode - 4'h1;
            end
        end
    end
endmodule // dbs_impedance_cal

// ==== core/dbs_memory_end.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - each command moves exactly two beats
// - back-to-back commands accepted every cycle
// - command sampled on true-clock edge only
// - deselect pipelined like a read
// - deselect ignores address, waits outstanding bursts
// - write beat one one cycle after command
// - second beat on complement edge, one word
// - masks sampled with each data beat
// - masked byte keeps old contents
// - mask n covers bits 9n..9n+8
// - any byte in either beat maskable
// - pll disabled while pll_disable_n low
// - tied reference selects minimum impedance
// - cycle counter retriggers impedance evaluation
// - impedance moves one step per evaluation
// - drivers released two cycles after nop/write
// - termination off half cycle around reads
module dbs_memory_end #(
    parameter int BW = dbs_pkg::BEAT_WIDTH,
    parameter int AW = dbs_pkg::ADDR_WIDTH,
    parameter int INTERVAL = dbs_pkg::CAL_INTERVAL_CYCLES
) (
    dbs_if.memory link,
    input wire logic [dbs_pkg::IMP_CODE_WIDTH-1:0] calTarget,
    output logic pllEnabled,
    output logic terminationActive,
    output logic [dbs_pkg::IMP_CODE_WIDTH-1:0] driverCode,
    output logic calEvent
);
    localparam int MW = BW / dbs_pkg::BYTE_BITS;
    // ****************************************
    // storage and pipeline
    // ****************************************
    logic [2*BW-1:0] mem [2**AW];
    dbs_pkg::dbs_cmd_t cmdStage [dbs_pkg::READ_LATENCY_CYCLES];
    logic [AW-1:0] addrStage [dbs_pkg::READ_LATENCY_CYCLES];
    logic [BW-1:0] firstData;
    logic [MW-1:0] firstMask;
    logic writePending;
    logic secondPending;
    logic [AW-1:0] writeAddr;
    logic [BW-1:0] readHigh;
    logic readSecond;
    logic linkTied;

    function automatic logic [BW-1:0] merge(input logic [BW-1:0] oldV, input logic [BW-1:0] newV,
                                            input logic [MW-1:0] maskN);
        logic [BW-1:0] r;
        r = oldV;
        for (int b = 0; b < MW; b++) begin
            if (!maskN[b]) begin
                r[b*dbs_pkg::BYTE_BITS +: dbs_pkg::BYTE_BITS] =
                    newV[b*dbs_pkg::BYTE_BITS +: dbs_pkg::BYTE_BITS];
            end
        end
        return r;
    endfunction

    // ****************************************
    // command pipeline
    // ****************************************
    always_ff @(posedge link.clock) begin
        if (link.reset) begin
            cmdStage[0] <= dbs_pkg::DBS_CMD_NOP;
            cmdStage[1] <= dbs_pkg::DBS_CMD_NOP;
            addrStage[0] <= '0;
            addrStage[1] <= '0;
        end else if (link.kRise) begin
            // deselect travels the same depth as a read
            if (link.load_n) begin
                cmdStage[0] <= dbs_pkg::DBS_CMD_NOP;
            end else if (link.readNotWrite) begin
                cmdStage[0] <= dbs_pkg::DBS_CMD_READ;
            end else begin
                cmdStage[0] <= dbs_pkg::DBS_CMD_WRITE;
            end
            addrStage[0] <= link.sync_address_in;
            cmdStage[1] <= cmdStage[0];
            addrStage[1] <= addrStage[0];
        end
    end

    // ****************************************
    // late write capture
    // ****************************************
    always_ff @(posedge link.clock) begin
        if (link.reset) begin
            writePending <= 1'b0;
            secondPending <= 1'b0;
            firstData <= '0;
            firstMask <= '1;
            writeAddr <= '0;
        end else begin
            if (link.kRise) begin
                writePending <= !link.load_n && !link.readNotWrite;
                if (writePending) begin
                    firstData <= link.dataBus;
                    firstMask <= link.byte_write_mask_n;
                    writeAddr <= addrStage[0];
                    secondPending <= 1'b1;
                end
            end else if (link.kbRise) begin
                secondPending <= 1'b0;
            end
        end
    end

    always_ff @(posedge link.clock) begin
        if (link.kbRise && secondPending && !link.reset) begin
            // both beats land in the array together
            mem[writeAddr] <= {merge(mem[writeAddr][2*BW-1:BW], link.dataBus,
                                     link.byte_write_mask_n),
                               merge(mem[writeAddr][BW-1:0], firstData, firstMask)};
        end
    end

    // ****************************************
    // read data output
    // ****************************************
    always_ff @(posedge link.clock) begin
        if (link.reset) begin
            link.memDataOut <= '0;
            link.memDataOe <= 1'b0;
            link.read_valid_out <= 1'b0;
            link.echo_clock <= 1'b0;
            link.echoClockN <= 1'b0;
            readHigh <= '0;
            readSecond <= 1'b0;
        end else if (link.kRise) begin
            link.echo_clock <= 1'b1;
            link.echoClockN <= 1'b0;
            readSecond <= 1'b0;
            if (cmdStage[1] == dbs_pkg::DBS_CMD_READ) begin
                link.memDataOut <= mem[addrStage[1]][BW-1:0];
                readHigh <= mem[addrStage[1]][2*BW-1:BW];
                link.memDataOe <= 1'b1;
                link.read_valid_out <= 1'b1;
                readSecond <= 1'b1;
            end else begin
                link.memDataOe <= 1'b0;
                link.read_valid_out <= 1'b0;
            end
        end else if (link.kbRise) begin
            link.echo_clock <= 1'b0;
            link.echoClockN <= 1'b1;
            if (readSecond) begin
                link.memDataOut <= readHigh;
            end
        end
    end

    // termination off whenever drivers will be or are on; kb edge is the half cycle
    always_ff @(posedge link.clock) begin
        if (link.reset) begin
            terminationActive <= 1'b0;
        end else if (link.kbRise) begin
            terminationActive <= link.termination_enable &&
                cmdStage[1] != dbs_pkg::DBS_CMD_READ && !readSecond;
        end
    end

    always_ff @(posedge link.clock) begin
        if (link.reset) begin
            pllEnabled <= 1'b0;
        end else begin
            pllEnabled <= link.pll_disable_n;
        end
    end

    assign linkTied = link.impedance_reference;

    dbs_impedance_cal #(
        .INTERVAL(INTERVAL)
    ) u_cal (
        .clock(link.clock),
        .reset(link.reset),
        .tiedToSupply(linkTied),
        .targetCode(calTarget),
        .driverCode(driverCode),
        .evalPulse(calEvent)
    );
endmodule // dbs_memory_end

// ==== core/dbs_pkg.sv ====
package dbs_pkg;
    // ****************************************
    // geometry
    // ****************************************
    localparam int BEAT_WIDTH = 18;
    localparam int BYTE_BITS = 9;
    localparam int MASK_WIDTH = BEAT_WIDTH / BYTE_BITS;
    localparam int ADDR_WIDTH = 4;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLOCK_MHZ = 250;
    localparam int READ_LATENCY_CYCLES = 2;
    localparam int CAL_INTERVAL_US = 1;
    localparam int CAL_INTERVAL_CYCLES = CAL_INTERVAL_US * CLOCK_MHZ;
    localparam int IMP_CODE_WIDTH = 4;
    localparam logic [IMP_CODE_WIDTH-1:0] IMP_CODE_RESET = 4'h8;
    localparam logic [IMP_CODE_WIDTH-1:0] IMP_CODE_MIN = 4'hF;
    // ****************************************
    // commands
    // ****************************************
    typedef enum logic [1:0] {
        DBS_CMD_NOP = 2'b00,
        DBS_CMD_READ = 2'b01,
        DBS_CMD_WRITE = 2'b10
    } dbs_cmd_t;
endpackage

// ==== verification/dbs_asserts.sv ====
`timescale 1ns/1ps
module dbs_asserts (
    input wire logic clock,
    input wire logic reset,
    input wire logic kRise,
    input wire logic kbRise,
    input wire logic load_n,
    input wire logic readNotWrite,
    input wire logic ctlDataOe,
    input wire logic memDataOe,
    input wire logic echo_clock,
    input wire logic echoClockN,
    input wire logic read_valid_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // ****************************************
    // helpers
    // ****************************************
    // saturating count of cycles since the last load
    logic [3:0] idleCount;
    always_ff @(posedge clock) begin
        if (reset || (kRise && !load_n)) idleCount <= 4'h0;
        else if (idleCount != 4'hF) idleCount <= idleCount + 4'h1;
    end
    sequence readCmd;
        kRise && !load_n && readNotWrite;
    endsequence
    sequence writeCmd;
        kRise && !load_n && !readNotWrite;
    endsequence
    sequence writeBeats;
        (ctlDataOe && kRise) ##1 (ctlDataOe && kbRise);
    endsequence
    sequence readBeats;
        (read_valid_out && echo_clock) ##1 (read_valid_out && echoClockN);
    endsequence
    // ****************************************
    // checks
    // ****************************************
    chk_phase_alternate: assert property (kRise |=> kbRise && !kRise)
        else $error("true edge not followed by complement edge");
    chk_read_latency: assert property (readCmd |-> ##5 readBeats)
        else $error("read data not delivered in time");
    // valid rises after a true edge, so the first sample is a complement phase
    chk_read_two_beats: assert property (
        $rose(read_valid_out) |-> kbRise ##1 (read_valid_out && kRise))
        else $error("read beats not true then complement");
    chk_valid_drives: assert property (read_valid_out |-> memDataOe)
        else $error("read valid without data drive");
    chk_write_late: assert property (writeCmd |-> ##2 writeBeats)
        else $error("write beats not late-write timed");
    chk_bus_single: assert property (!(memDataOe && ctlDataOe))
        else $error("both ends drive the data bus");
    chk_idle_release: assert property (
        idleCount >= 4'hA |-> !memDataOe && !read_valid_out)
        else $error("drivers not released after deselect");
    chk_echo_exclusive: assert property (echo_clock |-> !echoClockN)
        else $error("echo clocks overlap");
endmodule // dbs_asserts

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    localparam int BW = dbs_pkg::BEAT_WIDTH;
    localparam int AW = dbs_pkg::ADDR_WIDTH;
    localparam int BB = dbs_pkg::BYTE_BITS;
    localparam int MW = 2 * BW / BB;
    // short calibration period keeps the run brief
    localparam int INTERVAL = 8;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic reqValid = 1'b0;
    logic reqRead = 1'b0;
    logic [AW-1:0] reqAddr = '0;
    logic [2*BW-1:0] reqData = '0;
    logic [MW-1:0] reqMaskN = '1;
    logic rspReady = 1'b0;
    logic [3:0] calTarget = 4'h8;
    logic reqReady, rspValid, pllEnabled, terminationActive, calEvent;
    logic [2*BW-1:0] rspData;
    logic [3:0] driverCode, prevCode, evalTarget, stepExp;
    logic [2*BW-1:0] model [2**AW];
    logic [2*BW-1:0] expQ [$];
    int errCount = 0;
    int testsRun = 0;
    int sinceEval = 0;
    bit evalSeen = 0;
    bit stall = 1;
    initial forever #2 clock = ~clock;
    dbs_if #(.BW(BW), .AW(AW)) dbs_if_i (.clock(clock), .reset(reset));
    dbs_controller_end #(.BW(BW), .AW(AW)) dbs_controller_end_i (.link(dbs_if_i),
        .reqValid(reqValid), .reqReady(reqReady), .reqRead(reqRead), .reqAddr(reqAddr),
        .reqData(reqData), .reqMaskN(reqMaskN), .rspValid(rspValid), .rspReady(rspReady),
        .rspData(rspData));
    dbs_memory_end #(.BW(BW), .AW(AW), .INTERVAL(INTERVAL)) dbs_memory_end_i (
        .link(dbs_if_i), .calTarget(calTarget), .pllEnabled(pllEnabled),
        .terminationActive(terminationActive), .driverCode(driverCode), .calEvent(calEvent));
    dbs_asserts dbs_asserts_i (.clock(clock), .reset(reset), .kRise(dbs_if_i.kRise),
        .kbRise(dbs_if_i.kbRise), .load_n(dbs_if_i.load_n),
        .readNotWrite(dbs_if_i.readNotWrite), .ctlDataOe(dbs_if_i.ctlDataOe),
        .memDataOe(dbs_if_i.memDataOe), .echo_clock(dbs_if_i.echo_clock),
        .echoClockN(dbs_if_i.echoClockN), .read_valid_out(dbs_if_i.read_valid_out));
    // ****************************************
    // compare and closing
    // ****************************************
    task automatic checkWord(input string what, input logic [2*BW-1:0] e,
                             input logic [2*BW-1:0] s);
        testsRun++;
        if (s !== e) begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic checkCode(input string what, input logic [3:0] e, input logic [3:0] s);
        testsRun++;
        if (s !== e) begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic completeRun();
        if (errCount == 0 && testsRun > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic logic [2*BW-1:0] rnd();
        logic [63:0] r;
        r = {$urandom, $urandom};
        return r[2*BW-1:0];
    endfunction
    // ****************************************
    // drivers
    // ****************************************
    task automatic issue(input logic rd, input logic [AW-1:0] a, input logic [MW-1:0] m);
        logic [2*BW-1:0] d;
        d = rnd();
        @(negedge clock);
        reqValid = 1'b1;
        reqRead = rd;
        reqAddr = a;
        reqData = d;
        reqMaskN = m;
        #1;
        while (reqReady !== 1'b1) begin
            @(negedge clock);
            #1;
        end
        if (rd) expQ.push_back(model[a]);
        // low mask bit keeps the byte, high leaves old contents
        for (int i = 0; i < MW; i++) begin
            if (!rd && !m[i]) model[a][i*BB +: BB] = d[i*BB +: BB];
        end
        @(posedge clock);
    endtask
    task automatic idle(input int n);
        @(negedge clock);
        reqValid = 1'b0;
        repeat (n) @(negedge clock);
    endtask
    always @(negedge clock) rspReady <= stall ? 1'($urandom_range(0, 1)) : 1'b1;
    // ****************************************
    // monitors
    // ****************************************
    always @(posedge clock) begin
        if (!reset && rspValid === 1'b1 && rspReady === 1'b1) begin
            if (expQ.size() == 0) checkWord("rspData extra", ~rspData, rspData);
            else checkWord("rspData", expQ.pop_front(), rspData);
        end
        if (!reset && dbs_if_i.memDataOe === 1'b1)
            checkCode("termination", 4'h0, {3'h0, terminationActive});
        // the step follows the target seen at the evaluation, not a later one
        if (!reset && driverCode !== prevCode) begin
            stepExp = evalTarget > prevCode ? prevCode + 4'h1 : prevCode - 4'h1;
            checkCode("cal step", stepExp, driverCode);
        end
        prevCode = driverCode;
        if (reset) evalSeen = 0;
        else if (calEvent === 1'b1) begin
            if (evalSeen) checkCode("cal interval", 4'(INTERVAL), 4'(sinceEval));
            evalTarget = calTarget;
            evalSeen = 1;
            sinceEval = 0;
        end
        sinceEval++;
    end
    initial begin
        #200000;
        errCount++;
        completeRun();
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        void'($urandom(32'h89EE));
        repeat (6) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        @(negedge clock);
        checkCode("driverCode", dbs_pkg::IMP_CODE_RESET, driverCode);
        checkCode("pllEnabled", 4'h1, {3'h0, pllEnabled});
        for (int a = 0; a < 2**AW; a++) issue(1'b0, AW'(a), '0);
        for (int a = 0; a < 2**AW; a++) issue(1'b1, AW'(a), '0);
        for (int m = 0; m < 2**MW; m++) begin
            issue(1'b0, 4'h3, MW'(m));
            issue(1'b1, 4'h3, '0);
        end
        for (int n = 0; n < 80; n++) begin
            issue(1'($urandom), AW'($urandom), MW'($urandom));
            if ($urandom_range(0, 3) == 0) idle($urandom_range(1, 4));
        end
        idle(1);
        foreach (calTarget[i]) begin
            calTarget = i == 0 ? 4'h0 : (i == 1 ? dbs_pkg::IMP_CODE_MIN : 4'($urandom));
            repeat (20 * INTERVAL) @(negedge clock);
            checkCode("cal converged", calTarget, driverCode);
        end
        stall = 0;
        for (int w = 0; w < 200 && expQ.size() != 0; w++) @(negedge clock);
        checkCode("queue empty", 4'h0, 4'(expQ.size()));
        completeRun();
    end
endmodule // testbench
